// ### cod_pkg.sv
// package: object dictionary constants and carrier types for the actuator node
package cod_pkg;
  // communication object base identifiers
  localparam logic [10:0] COB_TPDO_BASE  = 11'h180;
  localparam logic [10:0] COB_RPDO_BASE  = 11'h200;
  localparam logic [10:0] COB_SDO_TX     = 11'h580;
  localparam logic [10:0] COB_SDO_RX     = 11'h600;
  localparam logic [10:0] COB_HBEAT      = 11'h700;
  // object indices
  localparam logic [15:0] IDX_DEV_TYPE   = 16'h1000;
  localparam logic [15:0] IDX_ERR_REG    = 16'h1001;
  localparam logic [15:0] IDX_HBEAT      = 16'h1017;
  localparam logic [15:0] IDX_IDENTITY   = 16'h1018;
  localparam logic [15:0] IDX_SDO_PAR    = 16'h1200;
  localparam logic [15:0] IDX_RPDO_PAR   = 16'h1400;
  localparam logic [15:0] IDX_RPDO_MAP   = 16'h1600;
  localparam logic [15:0] IDX_TPDO_PAR   = 16'h1800;
  localparam logic [15:0] IDX_TPDO_MAP   = 16'h1A00;
  localparam logic [15:0] IDX_ACT_POS    = 16'h2210;
  localparam logic [15:0] IDX_DES_POS    = 16'h2211;
  localparam logic [15:0] IDX_TEMP       = 16'h2212;
  localparam logic [15:0] IDX_STAT1      = 16'h2213;
  localparam logic [15:0] IDX_STAT2      = 16'h2214;
  localparam logic [15:0] IDX_STAT3      = 16'h2215;
  localparam logic [15:0] IDX_POS_CMD    = 16'h2216;
  localparam logic [15:0] IDX_VOLT       = 16'h2219;
  localparam logic [15:0] IDX_CURR       = 16'h221A;
  localparam logic [15:0] IDX_ANA_DEM    = 16'h221B;
  localparam logic [15:0] IDX_PWM_DEM    = 16'h221C;
  localparam logic [15:0] IDX_CAN_DEM    = 16'h221D;
  localparam logic [15:0] IDX_CLR_DIAG   = 16'h221F;
  localparam logic [15:0] IDX_CMD_BITS   = 16'h2220;
  localparam logic [15:0] IDX_STAT_DATA  = 16'h2221;
  // fixed values
  localparam logic [31:0] DEV_TYPE_VAL   = 32'h0000_0000;
  localparam logic [31:0] ERR_REG_VAL    = 32'h0000_0000;
  localparam logic [31:0] IDENT_ENTRIES  = 32'h0000_0004;
  localparam logic [31:0] SDO_ENTRIES    = 32'h0000_0002;
  localparam logic [31:0] RPDO_ELEMS     = 32'h0000_0002;
  localparam logic [31:0] RPDO_TTYPE     = 32'h0000_00FE;
  localparam logic [31:0] RPDO_MAP_N     = 32'h0000_0003;
  localparam logic [31:0] TPDO_MAX_SUB   = 32'h0000_0005;
  localparam logic [31:0] TPDO_TTYPE     = 32'h0000_0001;
  localparam logic [31:0] TPDO_EVT_TMR   = 32'h0000_0000;
  localparam logic [31:0] TPDO_MAP_N     = 32'h0000_0006;
  localparam logic [31:0] REV_PRELIM_MIN = 32'h0000_0064;
  localparam logic [31:0] ABORT_NO_SUB   = 32'h0609_0011;
  localparam logic [31:0] ABORT_NO_OBJ   = 32'h0602_0000;
  localparam logic [31:0] ABORT_WRITE    = 32'h0601_0002;
  localparam logic [15:0] POS_FULL       = 16'h9C40;
  localparam logic [15:0] POS_MAX        = 16'hFAFF;
  localparam logic [7:0]  TEMP_MAX       = 8'hFA;
  // mapping entry: index, sub-index, bit length
  localparam logic [7:0]  MAP_LEN16      = 8'h10;
  localparam logic [7:0]  MAP_LEN8       = 8'h08;
  localparam logic [7:0]  MAP_LEN1       = 8'h01;
  // demand source selections
  localparam logic [1:0]  SRC_ANALOG     = 2'h0;
  localparam logic [1:0]  SRC_PWM        = 2'h1;
  localparam logic [1:0]  SRC_CAN        = 2'h2;
  // byte positions in a frame
  localparam int          PDO_BYTES      = 8;
  // timing: fault timeout tick is one millisecond
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          MS_PER_TICK    = 1;
  localparam int          TICK_CYCLES    = CLK_HZ / 1000 * MS_PER_TICK;

  typedef enum logic [1:0] {
    COD_NMT_PREOP = 2'b00,
    COD_NMT_OPER  = 2'b01,
    COD_NMT_STOP  = 2'b10
  } cod_nmt_t;

  typedef struct packed {
    logic       valid;
    logic       is_write;
    logic [15:0] index;
    logic [7:0]  sub;
  } cod_sdo_req_t;

  typedef struct packed {
    logic        abort;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] data;
  } cod_sdo_rsp_t;

  typedef struct packed {
    logic [7:0] overall;
    logic [7:0] inputs;
    logic [7:0] system;
  } cod_status_t;

  typedef struct packed {
    logic [10:0]      cob_id;
    logic [63:0]      data;
  } cod_frame_t;

  typedef struct packed {
    logic [15:0] pos_act;
    logic [15:0] pos_des;
    logic [7:0]  temp;
    logic [15:0] volt;
    logic [15:0] curr;
    logic [15:0] ana_dem;
    logic [15:0] pwm_dem;
    logic [7:0]  stat_data;
  } cod_meas_t;
endpackage

// ### cod_dictionary.sv
// object dictionary, sdo server and pdo packing for the actuator node
`timescale 1ns/1ps
`default_nettype none
module cod_dictionary
  import cod_pkg::*;
#(
  parameter logic [31:0] VENDOR_ID   = 32'h0000_0A5A, // arbitrary value
  parameter logic [31:0] PRODUCT_ID  = 32'h0000_1234, // arbitrary value
  parameter logic [31:0] REVISION    = 32'h0000_0001,
  parameter logic [31:0] SERIAL_NUM  = 32'h0000_0001,
  parameter int          TICK_DIV    = TICK_CYCLES
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // configuration
  input  wire logic [6:0]   node_id,
  input  wire logic [15:0]  hbeat_ms,
  input  wire logic [15:0]  demand_timeout_ms,
  input  wire logic [1:0]   demand_source,
  input  wire cod_nmt_t     nmt_state,
  // actuator indications
  input  wire cod_meas_t    meas,
  input  wire cod_status_t  status,
  input  wire logic         bus_off,
  // sdo request and response
  input  wire cod_sdo_req_t sdo_req,
  output logic              sdo_req_ready,
  output logic              sdo_rsp_valid,
  input  wire logic         sdo_rsp_ready,
  output cod_sdo_rsp_t      sdo_rsp,
  output logic [10:0]       sdo_rsp_cob,
  // received process data
  input  wire logic         rpdo_valid,
  input  wire logic [10:0]  rpdo_cob,
  input  wire logic [31:0]  rpdo_data,
  // transmit process data
  input  wire logic         tpdo_trigger,
  output logic              tpdo_valid,
  input  wire logic         tpdo_ready,
  output cod_frame_t        tpdo,
  // demand outputs and heartbeat id
  output logic [15:0]       pos_demand,
  output logic [7:0]        clear_diag_cmd,
  output logic [7:0]        cmd_bits,
  output logic              demand_fault,
  output logic              demand_range_err,
  output logic [10:0]       hbeat_cob
);

  typedef struct packed {
    cod_sdo_rsp_t [1:0] buf_q;
    logic               wr_q;
    logic               rd_q;
    logic [1:0]         cnt_q;
    logic [10:0]        rsp_cob;
    logic [15:0]        pos_dem;
    logic [15:0]        can_dem;
    logic [7:0]         clr;
    logic [7:0]         cmd;
    logic [15:0]        tick_cnt;
    logic [15:0]        ms_cnt;
    logic               fault;
    logic               range_err;
    logic               tx_valid;
    cod_frame_t         tx;
  } cod_state_t;

  cod_state_t st_q;
  cod_state_t st_d;

  // object lookup; abort flag rides in bit 32
  function automatic logic [32:0] lookup(input logic [15:0] idx, input logic [7:0] sub,
                                          input logic [1:0] src);
    logic [32:0] r;
    logic        s0;
    r  = {1'b1, ABORT_NO_SUB};
    s0 = (sub == 8'h00);
    case (idx)
      IDX_DEV_TYPE: if (s0) r = {1'b0, DEV_TYPE_VAL};
      IDX_ERR_REG:  if (s0) r = {1'b0, ERR_REG_VAL};
      IDX_HBEAT:    if (s0) r = {17'h0, hbeat_ms};
      IDX_IDENTITY: begin
        case (sub)
          8'h00:   r = {1'b0, IDENT_ENTRIES};
          8'h01:   r = {1'b0, VENDOR_ID};
          8'h02:   r = {1'b0, PRODUCT_ID};
          8'h03:   r = {1'b0, REVISION};
          8'h04:   r = {1'b0, SERIAL_NUM};
          default: r = {1'b1, ABORT_NO_SUB};
        endcase
      end
      IDX_SDO_PAR: begin
        case (sub)
          8'h00:   r = {1'b0, SDO_ENTRIES};
          8'h01:   r = {22'h0, COB_SDO_RX + {4'h0, node_id}};
          8'h02:   r = {22'h0, COB_SDO_TX + {4'h0, node_id}};
          default: r = {1'b1, ABORT_NO_SUB};
        endcase
      end
      IDX_RPDO_PAR: begin
        case (sub)
          8'h00:   r = {1'b0, RPDO_ELEMS};
          8'h01:   r = {22'h0, COB_RPDO_BASE + {4'h0, node_id}};
          8'h02:   r = {1'b0, RPDO_TTYPE};
          default: r = {1'b1, ABORT_NO_SUB};
        endcase
      end
      IDX_RPDO_MAP: begin
        case (sub)
          8'h00:   r = {1'b0, RPDO_MAP_N};
          8'h01:   r = {1'b0, IDX_POS_CMD, 8'h00, MAP_LEN16};
          8'h02:   r = {1'b0, IDX_CLR_DIAG, 8'h00, MAP_LEN8};
          8'h03:   r = {1'b0, IDX_CMD_BITS, 8'h00, MAP_LEN8};
          default: r = {1'b1, ABORT_NO_SUB};
        endcase
      end
      IDX_TPDO_PAR: begin
        case (sub)
          8'h00:   r = {1'b0, TPDO_MAX_SUB};
          8'h01:   r = {22'h0, COB_TPDO_BASE + {4'h0, node_id}};
          8'h02:   r = {1'b0, TPDO_TTYPE};
          8'h05:   r = {1'b0, TPDO_EVT_TMR};
          default: r = {1'b1, ABORT_NO_SUB};
        endcase
      end
      IDX_TPDO_MAP: begin
        case (sub)
          8'h00:   r = {1'b0, TPDO_MAP_N};
          8'h01:   r = {1'b0, IDX_ACT_POS, 8'h00, MAP_LEN16};
          8'h02:   r = {1'b0, IDX_DES_POS, 8'h00, MAP_LEN16};
          8'h03:   r = {1'b0, IDX_TEMP, 8'h00, MAP_LEN8};
          8'h04:   r = {1'b0, IDX_STAT1, 8'h00, MAP_LEN8};
          8'h05:   r = {1'b0, IDX_STAT2, 8'h00, MAP_LEN8};
          8'h06:   r = {1'b0, IDX_STAT3, 8'h00, MAP_LEN8};
          default: r = {1'b1, ABORT_NO_SUB};
        endcase
      end
      IDX_ACT_POS:   if (s0) r = {17'h0, meas.pos_act};
      IDX_DES_POS:   if (s0) r = {17'h0, meas.pos_des};
      IDX_TEMP:      if (s0) r = {25'h0, meas.temp};
      IDX_STAT1:     if (s0) r = {25'h0, status.overall};
      IDX_STAT2:     if (s0) r = {25'h0, status.inputs};
      IDX_STAT3:     if (s0) r = {25'h0, status.system};
      IDX_VOLT:      if (s0) r = {17'h0, meas.volt};
      IDX_CURR:      if (s0) r = {17'h0, meas.curr};
      // invalid sources read as zero
      IDX_ANA_DEM:   if (s0) r = {17'h0, (src == SRC_ANALOG) ? meas.ana_dem : 16'h0000};
      IDX_PWM_DEM:   if (s0) r = {17'h0, (src == SRC_PWM) ? meas.pwm_dem : 16'h0000};
      IDX_CAN_DEM:   if (s0) r = {17'h0, (src == SRC_CAN) ? st_q.can_dem : 16'h0000};
      IDX_STAT_DATA: if (s0) r = {25'h0, meas.stat_data};
      IDX_POS_CMD, IDX_CLR_DIAG, IDX_CMD_BITS: r = {1'b1, ABORT_WRITE};
      default:       r = {1'b1, ABORT_NO_OBJ};
    endcase
    return r;
  endfunction

  logic [32:0]  look;
  cod_sdo_rsp_t rsp_new;
  logic         push;
  logic         pop;
  logic         oper;
  logic         rx_hit;
  logic [15:0]  rx_dem;

  assign oper          = (nmt_state == COD_NMT_OPER);
  assign sdo_req_ready = (st_q.cnt_q != 2'h2) && (nmt_state != COD_NMT_STOP);
  assign push          = sdo_req.valid && sdo_req_ready;
  assign pop           = sdo_rsp_valid && sdo_rsp_ready;
  assign sdo_rsp_valid = (st_q.cnt_q != 2'h0);
  assign sdo_rsp       = st_q.buf_q[st_q.rd_q];
  assign sdo_rsp_cob   = st_q.rsp_cob;
  assign tpdo_valid    = st_q.tx_valid;
  assign tpdo          = st_q.tx;
  assign pos_demand    = st_q.pos_dem;
  assign clear_diag_cmd = st_q.clr;
  assign cmd_bits      = st_q.cmd;
  assign demand_fault  = st_q.fault;
  assign demand_range_err = st_q.range_err;
  assign hbeat_cob     = COB_HBEAT + {4'h0, node_id};
  assign rx_hit        = rpdo_valid && oper && (rpdo_cob == COB_RPDO_BASE + {4'h0, node_id});
  assign rx_dem        = {rpdo_data[15:8], rpdo_data[7:0]};

  always_comb begin
    st_d = st_q;
    look = lookup(sdo_req.index, sdo_req.sub, demand_source);
    rsp_new.index = sdo_req.index;
    rsp_new.sub   = sdo_req.sub;
    if (sdo_req.is_write) begin
      rsp_new.abort = 1'b1;
      rsp_new.data  = ABORT_WRITE;
    end else begin
      rsp_new.abort = look[32];
      rsp_new.data  = look[31:0];
    end
    // two-entry response buffer; stalled reader back-pressures requests
    st_d.rsp_cob = COB_SDO_TX + {4'h0, node_id};
    if (push) begin
      st_d.buf_q[st_q.wr_q] = rsp_new;
      st_d.wr_q = ~st_q.wr_q;
    end
    if (pop) begin
      st_d.rd_q = ~st_q.rd_q;
    end
    st_d.cnt_q = st_q.cnt_q + {1'b0, push} - {1'b0, pop};
    // millisecond tick for the demand timeout
    if (st_q.tick_cnt == 16'(TICK_DIV - 1)) begin
      st_d.tick_cnt = 16'h0000;
      if (st_q.ms_cnt != 16'hFFFF) begin
        st_d.ms_cnt = st_q.ms_cnt + 16'h0001;
      end
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 16'h0001;
    end
    if (rx_hit) begin
      st_d.can_dem   = rx_dem;
      st_d.clr       = rpdo_data[23:16];
      st_d.cmd       = rpdo_data[31:24];
      st_d.ms_cnt    = 16'h0000;
      st_d.fault     = 1'b0;
      st_d.range_err = 1'b0;
      if (demand_source == SRC_CAN) begin
        if (rx_dem > POS_MAX) begin
          st_d.pos_dem = 16'h0000;
          st_d.fault   = 1'b1;
        end else if (rx_dem > POS_FULL) begin
          st_d.pos_dem   = POS_FULL;
          st_d.range_err = 1'b1;
        end else begin
          st_d.pos_dem = rx_dem;
        end
      end
    end else if (demand_source == SRC_CAN && st_q.ms_cnt >= demand_timeout_ms) begin
      st_d.fault = 1'b1;
    end
    // transmit frame, low byte first
    if (st_q.tx_valid && tpdo_ready) begin
      st_d.tx_valid = 1'b0;
    end
    if (tpdo_trigger && oper && !(st_q.tx_valid && !tpdo_ready)) begin
      st_d.tx_valid    = 1'b1;
      st_d.tx.cob_id   = COB_TPDO_BASE + {4'h0, node_id};
      st_d.tx.data[7:0]   = meas.pos_act[7:0];
      st_d.tx.data[15:8]  = meas.pos_act[15:8];
      st_d.tx.data[23:16] = meas.pos_des[7:0];
      st_d.tx.data[31:24] = meas.pos_des[15:8];
      st_d.tx.data[39:32] = (meas.temp > TEMP_MAX) ? TEMP_MAX : meas.temp;
      st_d.tx.data[47:40] = {1'b0, status.overall[6:0]};
      st_d.tx.data[55:48] = status.inputs;
      st_d.tx.data[63:56] = {2'b00, status.system[5], status.system[4] | bus_off
                             | st_q.fault | st_q.range_err, status.system[3:0]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule
`default_nettype wire

// ### cod_dictionary_assertions.sv
// checker: port-level assertions for the object dictionary node
`timescale 1ns/1ps
`default_nettype none
module cod_dictionary_chk
  import cod_pkg::*;
(
  // clock and reset
  input wire logic         ref_clk,
  input wire logic         rst_b,
  // configuration
  input wire logic [6:0]   node_id,
  input wire logic [15:0]  hbeat_ms,
  input wire logic [15:0]  demand_timeout_ms,
  input wire logic [1:0]   demand_source,
  input wire cod_nmt_t     nmt_state,
  // indications
  input wire cod_meas_t    meas,
  input wire cod_status_t  status,
  input wire logic         bus_off,
  // sdo
  input wire cod_sdo_req_t sdo_req,
  input wire logic         sdo_req_ready,
  input wire logic         sdo_rsp_valid,
  input wire logic         sdo_rsp_ready,
  input wire cod_sdo_rsp_t sdo_rsp,
  input wire logic [10:0]  sdo_rsp_cob,
  // process data
  input wire logic         rpdo_valid,
  input wire logic [10:0]  rpdo_cob,
  input wire logic [31:0]  rpdo_data,
  input wire logic         tpdo_trigger,
  input wire logic         tpdo_valid,
  input wire logic         tpdo_ready,
  input wire cod_frame_t   tpdo,
  // demand outputs and heartbeat id
  input wire logic [15:0]  pos_demand,
  input wire logic [7:0]   clear_diag_cmd,
  input wire logic [7:0]   cmd_bits,
  input wire logic         demand_fault,
  input wire logic         demand_range_err,
  input wire logic [10:0]  hbeat_cob
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic rx_ok;
  logic sdo_take;
  // only frames the node must take: operational, own id, bus demand source
  assign rx_ok = rpdo_valid && nmt_state == COD_NMT_OPER && demand_source == SRC_CAN
                 && rpdo_cob == COB_RPDO_BASE + 11'(node_id);
  // empty buffer, so the next head is this request's answer
  assign sdo_take = sdo_req.valid && sdo_req_ready && !sdo_rsp_valid;
  hbeat_id_a: assert property (hbeat_cob == COB_HBEAT + 11'(node_id))
    else $error("heartbeat id wrong");
  sdo_cob_a: assert property (sdo_rsp_valid |-> sdo_rsp_cob == COB_SDO_TX + 11'(node_id))
    else $error("sdo response id wrong");
  sdo_write_a: assert property (sdo_take && sdo_req.is_write |=>
    sdo_rsp_valid && sdo_rsp.abort && sdo_rsp.data == ABORT_WRITE)
    else $error("sdo write not refused");
  dev_type_a: assert property (sdo_take && !sdo_req.is_write &&
    sdo_req.index == IDX_DEV_TYPE && sdo_req.sub == 8'h00 |=>
    sdo_rsp_valid && !sdo_rsp.abort && sdo_rsp.data == DEV_TYPE_VAL)
    else $error("device type read wrong");
  stop_refuse_a: assert property (nmt_state == COD_NMT_STOP |-> !sdo_req_ready)
    else $error("sdo taken while stopped");
  rx_apply_a: assert property (rx_ok && rpdo_data[15:0] <= POS_FULL |=>
    pos_demand == $past(rpdo_data[15:0]) && cmd_bits == $past(rpdo_data[31:24]))
    else $error("position demand not applied");
  rx_clamp_a: assert property (rx_ok && rpdo_data[15:0] > POS_FULL &&
    rpdo_data[15:0] <= POS_MAX |=> pos_demand == POS_FULL && demand_range_err)
    else $error("demand not clamped");
  rx_idle_a: assert property (rpdo_valid && nmt_state != COD_NMT_OPER |=>
    $stable(pos_demand))
    else $error("demand taken outside operational");
  tx_hold_a: assert property (tpdo_valid && !tpdo_ready |=> tpdo_valid && $stable(tpdo))
    else $error("valve frame dropped under stall");
  tx_pack_a: assert property (tpdo_trigger && nmt_state == COD_NMT_OPER && !tpdo_valid
    |=> tpdo_valid && tpdo.data[15:0] == $past(meas.pos_act)
    && tpdo.cob_id == COB_TPDO_BASE + 11'(node_id))
    else $error("valve frame id or position wrong");
  tx_quiet_a: assert property (nmt_state != COD_NMT_OPER && !tpdo_valid |=> !tpdo_valid)
    else $error("valve frame outside operational");
endmodule
bind cod_dictionary cod_dictionary_chk u_chk (.*);
`default_nettype wire

// ### cod_master_model.sv
// partner: engine controller sending demand frames and taking valve frames
`timescale 1ns/1ps
`default_nettype none
module cod_master_model
  import cod_pkg::*;
(
  // clock
  input  wire logic       ref_clk,
  // demand frames to the node
  output logic            rpdo_valid,
  output logic [10:0]     rpdo_cob,
  output logic [31:0]     rpdo_data,
  // valve frames from the node
  input  wire logic       tpdo_valid,
  input  wire cod_frame_t tpdo,
  output logic            tpdo_ready,
  // stall length and capture
  input  wire logic [3:0] stall,
  output cod_frame_t      got,
  output logic [7:0]      got_cnt
);
  logic [3:0] wait_n;
  initial begin
    rpdo_valid = 1'b0;
    rpdo_cob   = 11'h000;
    rpdo_data  = 32'h0000_0000;
    tpdo_ready = 1'b0;
    wait_n     = 4'h0;
    got        = '0;
    got_cnt    = 8'h00;
  end
  // released data lines flip so a stale value is never mistaken for a frame
  task automatic send(input logic [10:0] cob, input logic [15:0] dem,
                      input logic [7:0] clr, input logic [7:0] cmd);
    @(negedge ref_clk);
    rpdo_valid <= 1'b1;
    rpdo_cob   <= cob;
    rpdo_data  <= {cmd, clr, dem};
    @(negedge ref_clk);
    rpdo_valid <= 1'b0;
    rpdo_data  <= ~{cmd, clr, dem};
  endtask
  always @(negedge ref_clk) begin
    wait_n     <= (tpdo_valid && !tpdo_ready) ? wait_n + 4'h1 : 4'h0;
    tpdo_ready <= tpdo_valid && !tpdo_ready && wait_n >= stall;
  end
  always @(posedge ref_clk) begin
    if (tpdo_valid && tpdo_ready) begin
      got     <= tpdo;
      got_cnt <= got_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### tb_canopen_actuator_object_dictionary.sv
// testbench: dictionary reads, buffer back-pressure, process data both ways
`timescale 1ns/1ps
`default_nettype none
module tb_canopen_actuator_object_dictionary import cod_pkg::*;;
  localparam logic [31:0] VEND = 32'h0000_0C3D; // arbitrary value
  localparam logic [6:0]  NODE = 7'h21;
  logic         ref_clk, rst_b, bus_off, rsp_rdy, trig, tr_ok, rv;
  logic [1:0]   src;
  cod_nmt_t     nmt;
  cod_meas_t    meas;
  cod_status_t  status;
  cod_sdo_req_t req;
  cod_sdo_rsp_t rsp;
  cod_frame_t   tpdo, got;
  logic         req_rdy, rsp_val, tv, dfault, drange;
  logic [10:0]  rsp_cob, hb_cob, rc;
  logic [31:0]  rd_;
  logic [15:0]  pdem;
  logic [7:0]   clr, cmd, got_cnt;
  logic [3:0]   stall;
  int           err_count, num_checks;
  cod_dictionary #(.VENDOR_ID(VEND), .TICK_DIV(4)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .node_id(NODE), .hbeat_ms(16'h01F4), .demand_timeout_ms(16'h0002),
    .demand_source(src), .nmt_state(nmt), .meas(meas), .status(status), .bus_off(bus_off),
    .sdo_req(req), .sdo_req_ready(req_rdy), .sdo_rsp_valid(rsp_val), .sdo_rsp_ready(rsp_rdy),
    .sdo_rsp(rsp), .sdo_rsp_cob(rsp_cob), .rpdo_valid(rv), .rpdo_cob(rc), .rpdo_data(rd_),
    .tpdo_trigger(trig), .tpdo_valid(tv), .tpdo_ready(tr_ok), .tpdo(tpdo),
    .pos_demand(pdem), .clear_diag_cmd(clr), .cmd_bits(cmd), .demand_fault(dfault),
    .demand_range_err(drange), .hbeat_cob(hb_cob));
  cod_master_model u_m (.ref_clk(ref_clk), .rpdo_valid(rv), .rpdo_cob(rc), .rpdo_data(rd_),
    .tpdo_valid(tv), .tpdo(tpdo), .tpdo_ready(tr_ok), .stall(stall), .got(got),
    .got_cnt(got_cnt));
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic put(input logic [15:0] ix, input logic [7:0] sb, input logic wr);
    int n;
    n = 0;
    @(negedge ref_clk);
    req = '{1'b1, wr, ix, sb};
    while (req_rdy !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk(64'(req_rdy), 64'h1);
    @(negedge ref_clk);
    req.valid = 1'b0;
  endtask
  task automatic get(input logic ab, input logic [31:0] d);
    int n;
    n = 0;
    // one edge between strobes so ready is never rewritten in one step
    @(negedge ref_clk);
    while (rsp_val !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk({rsp.abort, rsp.data}, {ab, d});
    rsp_rdy = 1'b1;
    @(negedge ref_clk);
    rsp_rdy = 1'b0;
  endtask
  task automatic rd(input logic [15:0] ix, input logic [7:0] sb, input logic ab,
                    input logic [31:0] d);
    put(ix, sb, 1'b0);
    get(ab, d);
  endtask
  task automatic t_dict;
    rd(IDX_DEV_TYPE, 8'h00, 1'b0, 32'h0);
    rd(IDX_DEV_TYPE, 8'h01, 1'b1, ABORT_NO_SUB);
    rd(IDX_ERR_REG, 8'h00, 1'b0, 32'h0);
    rd(IDX_ERR_REG, 8'h02, 1'b1, ABORT_NO_SUB);
    rd(IDX_HBEAT, 8'h00, 1'b0, 32'h0000_01F4);
    rd(IDX_IDENTITY, 8'h00, 1'b0, 32'h4);
    rd(IDX_IDENTITY, 8'h01, 1'b0, VEND);
    rd(IDX_SDO_PAR, 8'h01, 1'b0, 32'(COB_SDO_RX + 11'(NODE)));
    rd(IDX_SDO_PAR, 8'h02, 1'b0, 32'(COB_SDO_TX + 11'(NODE)));
    rd(IDX_RPDO_PAR, 8'h01, 1'b0, 32'(COB_RPDO_BASE + 11'(NODE)));
    rd(IDX_RPDO_PAR, 8'h02, 1'b0, 32'hFE);
    rd(IDX_RPDO_MAP, 8'h01, 1'b0, {IDX_POS_CMD, 16'h0010});
    rd(IDX_TPDO_PAR, 8'h00, 1'b0, 32'h5);
    rd(IDX_TPDO_PAR, 8'h02, 1'b0, 32'h1);
    rd(IDX_TPDO_PAR, 8'h05, 1'b0, 32'h0);
    rd(IDX_TPDO_MAP, 8'h03, 1'b0, {IDX_TEMP, 16'h0008});
    rd(IDX_VOLT, 8'h00, 1'b0, 32'h0000_FAFF);
    rd(IDX_CURR, 8'h00, 1'b0, 32'h0000_0000);
    rd(IDX_ANA_DEM, 8'h00, 1'b0, 32'h0000_0506);
    rd(IDX_PWM_DEM, 8'h00, 1'b0, 32'h0);
    rd(IDX_STAT_DATA, 8'h00, 1'b0, 32'hA5);
    rd(16'h3000, 8'h00, 1'b1, ABORT_NO_OBJ);
    put(IDX_POS_CMD, 8'h00, 1'b1);
    get(1'b1, ABORT_WRITE);
  endtask
  task automatic t_fill;
    put(IDX_DEV_TYPE, 8'h00, 1'b0);
    put(IDX_ERR_REG, 8'h01, 1'b0);
    @(negedge ref_clk);
    req.valid = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(64'(req_rdy), 64'h0);
    get(1'b0, 32'h0);
    // held request is taken once a slot frees, then released
    @(negedge ref_clk);
    req.valid = 1'b0;
    get(1'b1, ABORT_NO_SUB);
    get(1'b1, ABORT_NO_SUB);
  endtask
  task automatic t_tx;
    nmt = COD_NMT_OPER;
    stall = 4'h3;
    @(negedge ref_clk);
    trig = 1'b1;
    @(negedge ref_clk);
    trig = 1'b0;
    repeat (12) @(negedge ref_clk);
    chk(64'(got_cnt), 64'h1);
    chk(got.data, {8'h0F, 8'h81, 8'h7F, 8'h5E, 16'h3C4D, 16'hFAFF});
    chk(64'(got.cob_id), 64'(COB_TPDO_BASE + 11'(NODE)));
    bus_off = 1'b1;
    trig = 1'b1;
    @(negedge ref_clk);
    trig = 1'b0;
    bus_off = 1'b0;
    repeat (12) @(negedge ref_clk);
    chk(64'(got.data[63:56]), 64'h1F);
    nmt = COD_NMT_PREOP;
    trig = 1'b1;
    @(negedge ref_clk);
    trig = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk(64'(got_cnt), 64'h2);
  endtask
  task automatic t_rx;
    logic [10:0] me;
    me = COB_RPDO_BASE + 11'(NODE);
    u_m.send(me, 16'h1234, 8'h01, 8'h02);
    chk(64'(pdem), 64'h0);
    nmt = COD_NMT_OPER;
    u_m.send(me, 16'h1234, 8'h01, 8'h02);
    chk(64'(pdem), 64'h0);
    src = SRC_CAN;
    u_m.send(me, 16'h1234, 8'h01, 8'h02);
    chk({pdem, clr, cmd}, {16'h1234, 8'h01, 8'h02});
    u_m.send(me + 11'h001, 16'h0100, 8'h00, 8'h00);
    chk(64'(pdem), 64'h1234);
    u_m.send(me, 16'hA000, 8'h00, 8'h00);
    chk({pdem, drange}, {POS_FULL, 1'b1});
    u_m.send(me, 16'hFB00, 8'h00, 8'h00);
    chk({pdem, dfault}, {16'h0000, 1'b1});
    u_m.send(me, 16'h4000, 8'h00, 8'h00);
    chk({pdem, dfault}, {16'h4000, 1'b0});
    repeat (20) @(negedge ref_clk);
    chk(64'(dfault), 64'h1);
  endtask
  task automatic t_stop;
    nmt = COD_NMT_STOP;
    @(negedge ref_clk);
    chk(64'(req_rdy), 64'h0);
    chk(64'(hb_cob), 64'(COB_HBEAT + 11'(NODE)));
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    #(50 * 4000);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test;
  end
  initial begin
    err_count = 0;
    num_checks = 0;
    rst_b = 1'b0;
    bus_off = 1'b0;
    rsp_rdy = 1'b0;
    trig = 1'b0;
    src = SRC_ANALOG;
    nmt = COD_NMT_PREOP;
    stall = 4'h0;
    req = '0;
    meas = '{16'hFAFF, 16'h3C4D, 8'h5E, 16'hFAFF, 16'h0000, 16'h0506, 16'h0708, 8'hA5};
    status = '{8'hFF, 8'h81, 8'h0F};
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    chk(64'(hb_cob), 64'(COB_HBEAT + 11'(NODE)));
    t_dict;
    t_fill;
    t_tx;
    t_rx;
    t_stop;
    stop_test;
  end
endmodule
`default_nettype wire
